// *** shared/arq_pkg.sv ***
// Shared constants and types for the radio ARQ message queue.
// Assumes a single 125 MHz system clock.
package arq_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned CYCLE_US       = 4800;
  localparam int unsigned CYCLE_CLKS     = CYCLE_US * CLK_MHZ;
  localparam int unsigned MAX_RETRY_FIX  = 2;
  localparam int unsigned FRAME_W        = 108;
  localparam int unsigned TXQ_DEPTH      = 32;
  localparam int unsigned RXQ_DEPTH      = 32;
  localparam logic [1:0]  RETRY_RST      = 2'h2;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_WAIT = 4'b0010,
    TX_SEND = 4'b0100,
    TX_ACKW = 4'b1000
  } tx_state_t;
endpackage

// *** shared/stream_if.sv ***
// Valid/ready stream carrier between the queue and its users.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface stream_if #(parameter int unsigned W = 108);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// *** logic/msg_fifo.sv ***
// First-in first-out frame store with optional drop-oldest on overflow.
// Assumes a synchronous active-low reset on clk_sys.
`timescale 1ns/1ps
module msg_fifo #(
  parameter int unsigned W     = 108,
  parameter int unsigned DEPTH = 32,
  parameter bit          DROP  = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  stream_if.sink    wr,
  stream_if.src     rd,
  output logic      dropped
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          full;
  logic          push;
  logic          pop;
  logic          kick;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full     = (cnt_q == (AW+1)'(DEPTH));
  // Overflow evicts the oldest entry so the writer never stalls
  assign wr.ready = DROP ? 1'b1 : !full;
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;
  assign kick     = push && full && !pop;
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      dropped <= 1'b0;
    end else begin
      dropped <= kick;
      if (push) begin
        wp_q <= inc(wp_q);
      end
      if (pop || kick) begin
        rp_q <= inc(rp_q);
      end
      if (push && !pop && !full) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// *** logic/cycle_timer.sv ***
// Free-running transmission cycle timer giving one slot pulse per period.
// Assumes a synchronous active-low reset on clk_sys.
`timescale 1ns/1ps
module cycle_timer #(
  parameter int unsigned PERIOD = 600000
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  output logic      slot
);
  logic [$clog2(PERIOD)-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_q <= '0;
      slot  <= 1'b0;
    end else begin
      slot  <= (cnt_q == $bits(cnt_q)'(PERIOD - 1));
      cnt_q <= (cnt_q == $bits(cnt_q)'(PERIOD - 1)) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

// *** logic/radio_arq_message_queue.sv ***
// Message path of a CAN-to-radio bridge: transmit queue with ARQ, receive buffer.
// Assumes CAN controller and radio modem are synchronous to clk_sys.
//
// Behaviour
// - Resend any radio packet the peer did not acknowledge.
// - At most two resends by default, up to three when configured, then the message is discarded.
// - Retry limit is configurable in one variant, fixed at two in the other.
// - Deliver to the far side in local-bus order, also across resends.
// - A pending unacknowledged message is resent before any later message.
// - On transmit queue overflow drop messages, never stall the local bus.
// - Queue is oldest first: oldest sent next and dropped first.
// - Transmit opportunities come on a fixed 4.8 ms cycle slot.
// - Normal delay is half a cycle plus or minus half a cycle.
// - Each resend delays that message by one further 4.8 ms cycle.
// - Defer sending while the channel is busy, keeping queued messages.
// - Received messages are buffered for the local bus, dropped only on overflow.
// - Local bus frames are accepted immediately regardless of radio outcome.
`timescale 1ns/1ps
module radio_arq_message_queue
  import arq_pkg::*;
#(
  parameter int unsigned W            = arq_pkg::FRAME_W,
  parameter int unsigned TX_DEPTH     = arq_pkg::TXQ_DEPTH,
  parameter int unsigned RX_DEPTH     = arq_pkg::RXQ_DEPTH,
  parameter int unsigned CYCLE        = arq_pkg::CYCLE_CLKS,
  parameter bit          RETRY_CONFIG = 1'b1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [1:0]   retry_limit,
  input  wire logic         can_rx_valid,
  input  wire logic [W-1:0] can_rx_data,
  output logic              can_rx_ack,
  output logic              can_tx_valid,
  output logic [W-1:0]      can_tx_data,
  input  wire logic         can_tx_ready,
  input  wire logic         chan_busy,
  output logic              radio_tx_valid,
  output logic [W-1:0]      radio_tx_data,
  input  wire logic         radio_tx_ready,
  input  wire logic         radio_ack,
  input  wire logic         radio_rx_valid,
  input  wire logic [W-1:0] radio_rx_data,
  output logic              tx_dropped,
  output logic              tx_discarded,
  output logic              rx_dropped
);
  import arq_pkg::*;

  stream_if #(.W(W)) txq_in  ();
  stream_if #(.W(W)) txq_out ();
  stream_if #(.W(W)) rxq_in  ();
  stream_if #(.W(W)) rxq_out ();

  tx_state_t    state_q;
  logic [1:0]   tries_q;
  logic [1:0]   limit_q;
  logic [1:0]   limit_eff;
  logic         slot;
  logic         acked_q;
  logic [W-1:0] hold_q;

  // Frames are always accepted so the CAN side never waits on the radio
  assign txq_in.valid = can_rx_valid;
  assign txq_in.data  = can_rx_data;
  assign can_rx_ack   = can_rx_valid;

  msg_fifo #(.W(W), .DEPTH(TX_DEPTH), .DROP(1'b1)) u_txq (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wr      (txq_in.sink),
    .rd      (txq_out.src),
    .dropped (tx_dropped)
  );

  cycle_timer #(.PERIOD(CYCLE)) u_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .slot    (slot)
  );

  // Limit sampled only on a slot in TX_IDLE so a change mid-message does not tear a retry count
  assign limit_eff = RETRY_CONFIG ? limit_q : 2'(MAX_RETRY_FIX);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      limit_q <= RETRY_RST;
    end else if (slot && state_q == TX_IDLE) begin
      limit_q <= retry_limit;
    end
  end

  // Head stays in the queue until acked, given up or evicted on overflow, so nothing overtakes it
  assign txq_out.ready = (state_q == TX_ACKW) && slot &&
                         (acked_q || tries_q == limit_eff);

  assign radio_tx_valid = (state_q == TX_SEND);
  assign radio_tx_data  = hold_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hold_q <= '0;
    end else if (txq_out.valid && (state_q == TX_IDLE || state_q == TX_WAIT)) begin
      // Frozen while on air so an overflow eviction cannot change an offered packet
      hold_q <= txq_out.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acked_q <= 1'b0;
    end else if (state_q == TX_SEND) begin
      acked_q <= 1'b0;
    end else if (state_q == TX_ACKW && radio_ack) begin
      acked_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_discarded <= 1'b0;
    end else begin
      tx_discarded <= txq_out.ready && !acked_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= TX_IDLE;
      tries_q <= '0;
    end else begin
      case (state_q)
        TX_IDLE: begin
          if (slot && txq_out.valid) begin
            state_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          // A busy channel holds the frame for the next free moment
          if (!chan_busy) begin
            state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (radio_tx_ready) begin
            state_q <= TX_ACKW;
          end
        end
        TX_ACKW: begin
          if (slot) begin
            if (acked_q || tries_q == limit_eff) begin
              state_q <= TX_IDLE;
              tries_q <= '0;
            end else begin
              tries_q <= tries_q + 1'b1;
              state_q <= TX_WAIT;
            end
          end
        end
        default: begin
          state_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign rxq_in.valid = radio_rx_valid;
  assign rxq_in.data  = radio_rx_data;

  msg_fifo #(.W(W), .DEPTH(RX_DEPTH), .DROP(1'b1)) u_rxq (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wr      (rxq_in.sink),
    .rd      (rxq_out.src),
    .dropped (rx_dropped)
  );

  assign can_tx_valid  = rxq_out.valid;
  assign can_tx_data   = rxq_out.data;
  assign rxq_out.ready = can_tx_ready;
endmodule

// *** bench/radio_arq_asserts.sv ***
// Port-level checks for the ARQ message queue.
// Assumes one clock domain; bound into every queue instance.
`timescale 1ns/1ps
module radio_arq_asserts #(
  parameter int unsigned W = 108
) (
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire logic         can_rx_valid,
  input wire logic         can_rx_ack,
  input wire logic         can_tx_valid,
  input wire logic [W-1:0] can_tx_data,
  input wire logic         can_tx_ready,
  input wire logic         chan_busy,
  input wire logic         radio_tx_valid,
  input wire logic [W-1:0] radio_tx_data,
  input wire logic         radio_tx_ready,
  input wire logic         radio_rx_valid,
  input wire logic         tx_dropped,
  input wire logic         tx_discarded,
  input wire logic         rx_dropped
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_offer; radio_tx_valid && !radio_tx_ready; endsequence
  sequence s_held; can_tx_valid && !can_tx_ready && !radio_rx_valid; endsequence
  a_ack_at_once: assert property (can_rx_ack == can_rx_valid) else $error("ack late");
  a_busy_defers: assert property ($rose(radio_tx_valid) |-> !$past(chan_busy))
    else $error("sent while busy");
  a_offer_holds: assert property (s_offer |=> radio_tx_valid && $stable(radio_tx_data))
    else $error("offer changed");
  a_rx_stored: assert property (radio_rx_valid |=> can_tx_valid) else $error("rx lost");
  a_rx_head_holds: assert property (s_held |=> can_tx_valid && $stable(can_tx_data))
    else $error("rx head changed");
  a_drop_cause: assert property (tx_dropped |-> $past(can_rx_valid))
    else $error("tx drop without write");
  a_rxdrop_cause: assert property (rx_dropped |-> $past(radio_rx_valid))
    else $error("rx drop without write");
  a_discard_idle: assert property (tx_discarded |-> !radio_tx_valid)
    else $error("discard while sending");
endmodule

bind radio_arq_message_queue radio_arq_asserts #(.W(W)) chk_u (.clk_sys, .resetn,
  .can_rx_valid, .can_rx_ack, .can_tx_valid, .can_tx_data, .can_tx_ready, .chan_busy,
  .radio_tx_valid, .radio_tx_data, .radio_tx_ready, .radio_rx_valid, .tx_dropped,
  .tx_discarded, .rx_dropped);

// *** bench/radio_peer_model.sv ***
// Peer unit across the radio: accepts packets, acknowledges them.
// Assumes the bench resets it with the queue to clear its history.
`timescale 1ns/1ps
module radio_peer_model #(
  parameter int unsigned W = 108
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         tx_valid,
  input  wire logic [W-1:0] tx_data,
  output logic              tx_ready,
  output logic              ack,
  input  wire logic [3:0]   miss,
  input  wire logic         slow
);
  logic [W-1:0] got[$];
  int           seen;
  int           wait_n;
  // The first miss packets go unacknowledged; slow mode stalls each offer
  always @(posedge clk_sys) begin
    if (!resetn) begin
      got.delete();
      seen = 0;
      wait_n = 0;
      tx_ready <= 1'b0;
      ack      <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      ack      <= (seen >= miss);
      tx_ready <= 1'b0;
      seen++;
      wait_n = 0;
    end else begin
      ack      <= 1'b0;
      tx_ready <= tx_valid && (wait_n >= (slow ? 3 : 0));
      if (tx_valid) wait_n++;
    end
  end
endmodule

// *** bench/radio_arq_message_queue_tb.sv ***
// Self-checking bench for the ARQ message queue with a short cycle.
// Assumes the peer model and the bound checker.
`timescale 1ns/1ps
module radio_arq_message_queue_tb;
  import arq_pkg::*;
  localparam int unsigned CYC = 50;
  logic clk_sys = 0, resetn = 0, chan_busy = 0, can_rx_valid = 0, can_tx_ready = 0;
  logic radio_rx_valid = 0, slow = 0, can_rx_ack, can_tx_valid, radio_tx_valid;
  logic radio_tx_ready, radio_ack, tx_dropped, tx_discarded, rx_dropped;
  logic [1:0] retry_limit = 2'h2;
  logic [3:0] miss = 4'h0;
  logic [FRAME_W-1:0] can_rx_data = '0, radio_rx_data = '0, can_tx_data, radio_tx_data;
  logic [FRAME_W-1:0] rxq[$];
  int miscompares = 0, n_checks = 0, n_disc, n_drop, n_rxd;
  logic fx_valid, fx_ready, fx_ack;
  logic [FRAME_W-1:0] fx_data;
  radio_arq_message_queue #(.CYCLE(CYC)) dut_u (.clk_sys, .resetn, .retry_limit,
    .can_rx_valid, .can_rx_data, .can_rx_ack, .can_tx_valid, .can_tx_data, .can_tx_ready,
    .chan_busy, .radio_tx_valid, .radio_tx_data, .radio_tx_ready, .radio_ack,
    .radio_rx_valid, .radio_rx_data, .tx_dropped, .tx_discarded, .rx_dropped);
  radio_peer_model #(.W(FRAME_W)) peer_u (.clk_sys, .resetn, .tx_valid(radio_tx_valid),
    .tx_data(radio_tx_data), .tx_ready(radio_tx_ready), .ack(radio_ack), .miss, .slow);
  // Second unit of the variant with the fixed retry limit, fed the same stimulus
  radio_arq_message_queue #(.CYCLE(CYC), .RETRY_CONFIG(1'b0)) fix_u (.clk_sys, .resetn,
    .retry_limit, .can_rx_valid, .can_rx_data, .can_rx_ack(), .can_tx_valid(),
    .can_tx_data(), .can_tx_ready, .chan_busy, .radio_tx_valid(fx_valid),
    .radio_tx_data(fx_data), .radio_tx_ready(fx_ready), .radio_ack(fx_ack),
    .radio_rx_valid, .radio_rx_data, .tx_dropped(), .tx_discarded(), .rx_dropped());
  radio_peer_model #(.W(FRAME_W)) peer_fix_u (.clk_sys, .resetn, .tx_valid(fx_valid),
    .tx_data(fx_data), .tx_ready(fx_ready), .ack(fx_ack), .miss, .slow);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_disc += tx_discarded;
    n_drop += tx_dropped;
    n_rxd += rx_dropped;
    if (can_tx_valid && can_tx_ready) rxq.push_back(can_tx_data);
  end
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic rst(input logic b, input logic [3:0] m, input logic s);
    @(posedge clk_sys) #1 resetn = 0;
    chan_busy = b;
    miss = m;
    slow = s;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1;
    n_disc = 0;
    n_drop = 0;
    n_rxd = 0;
    rxq.delete();
  endtask
  task automatic snd(input int d);
    @(posedge clk_sys) #1 can_rx_valid = 1;
    can_rx_data = FRAME_W'(d);
    @(posedge clk_sys);
    chk(can_rx_ack === 1'b1, "frame not taken");
    #1 can_rx_valid = 0;
  endtask
  task automatic rcv(input int d);
    @(posedge clk_sys) #1 radio_rx_valid = 1;
    radio_rx_data = FRAME_W'(d);
    @(posedge clk_sys) #1 radio_rx_valid = 0;
  endtask
  task automatic slots(input int n);
    repeat (n * CYC) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_order;
    rst(0, 0, 0);
    for (int i = 1; i <= 3; i++) snd(i);
    slots(2);
    chk(peer_u.got.size() >= 1, "first frame late");
    slots(6);
    chk(peer_u.got.size() == 3 && n_disc == 0, "count");
    for (int i = 0; i < 3; i++) chk(peer_u.got[i] === FRAME_W'(i + 1), "order");
    $display("t_order done");
  endtask
  task automatic t_retry;
    for (int l = 0; l < 3; l++) begin
      rst(0, 15, 0);
      retry_limit = 2'(l);
      snd(9);
      slots(7);
      chk(peer_u.got.size() == l + 1, "send count");
      chk(n_disc == 1, "no discard");
      chk(peer_fix_u.got.size() == 3, "fixed limit");
    end
    $display("t_retry done");
  endtask
  task automatic t_resend;
    rst(0, 1, 1);
    snd(7);
    snd(8);
    slots(8);
    chk(peer_u.got.size() == 3 && peer_u.got[0] === FRAME_W'(7) && peer_u.got[1] === FRAME_W'(7)
        && peer_u.got[2] === FRAME_W'(8), "resend order");
    $display("t_resend done");
  endtask
  task automatic t_busy;
    rst(1, 0, 0);
    snd(5);
    slots(3);
    chk(peer_u.got.size() == 0, "sent while busy");
    chan_busy = 0;
    slots(3);
    chk(peer_u.got.size() == 1 && peer_u.got[0] === FRAME_W'(5), "kept frame");
    $display("t_busy done");
  endtask
  task automatic t_overflow;
    rst(1, 0, 0);
    for (int i = 0; i < 33; i++) snd(i);
    slots(1);
    chk(n_drop == 1, "drop count");
    chan_busy = 0;
    slots(4);
    chk(peer_u.got.size() > 0 && peer_u.got[0] === FRAME_W'(1), "oldest not dropped");
    $display("t_overflow done");
  endtask
  task automatic t_rx;
    rst(0, 0, 0);
    can_tx_ready = 0;
    for (int i = 0; i < 33; i++) rcv(i);
    // The drop pulse is registered, so let it reach the counter first
    slots(1);
    chk(n_rxd == 1, "rx drop count");
    can_tx_ready = 1;
    repeat (40) @(posedge clk_sys);
    #1;
    chk(rxq.size() == 32 && rxq[0] === FRAME_W'(1) && rxq[31] === FRAME_W'(32), "rx");
    chk(can_tx_valid === 1'b0, "rx not empty");
    $display("t_rx done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    t_order;
    t_retry;
    t_resend;
    t_busy;
    t_overflow;
    t_rx;
    conclude;
  end
  // About nine times the expected run length
  initial begin
    #200us;
    miscompares++;
    conclude;
  end
endmodule
